// ### design/watchdog_timer_reset_flags.sv
// Functional notes
// - Upper four bits of the reset-cause register always read zero.
// - Watchdog cause flag set by watchdog reset, cleared by power-on or written zero.
// - Brown-out cause flag set by brown-out, cleared by power-on or written zero.
// - External cause flag set by pin reset, cleared by power-on or written zero.
// - Power-on flag set by power-on reset, cleared only by written zero.
// - Time-out sets interrupt flag in interrupt modes; vector or written one clears.
// - Interrupt request needs global enable, watchdog enable and pending flag.
// - Fuse unprogrammed: enable bits pick mode; programmed: system reset mode.
// - Combined mode: first time-out sets flag; vector clears enable and flag.
// - Combined mode: time-out with flag still pending gives a system reset.
// - Change-enable clears itself four clock cycles after being set.
// - Clearing reset-enable or changing period needs change-enable set.
// - Reset-enable forced to one while watchdog cause flag is set.
// - Period select gives 2048 oscillator cycles doubled per code, up to code 9.
// - Watchdog stays enabled after a watchdog-caused reset.
// - Counter runs on the 128 kHz oscillator rate, not the system clock.
// - Reset-mode time-out gives a one system-clock-cycle reset pulse.
// - Restart instruction restarts the counter; software must issue it in time.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module watchdog_timer_reset_flags #(
    parameter int OSC_DIV    = wdt_pkg::OSC_DIV,
    parameter int BASE_TICKS = wdt_pkg::BASE_OSC_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       brownout_rst_in,
    input  wire logic       extpin_rst_in,
    input  wire logic       always_on_fuse_b_in,
    input  wire logic       global_irq_enable_in,
    input  wire logic       irq_vector_ack_in,
    input  wire logic       wdog_restart_in,
    output logic            timeout_irq_req_out,
    output logic            sys_reset_pulse_out,
    output logic      [1:0] mode_out
);

    localparam int CE_CW = $clog2(wdt_pkg::CHANGE_WINDOW_CYC);
    localparam logic [CE_CW-1:0] CE_LOAD = CE_CW'(wdt_pkg::CHANGE_WINDOW_CYC - 1);

    // Pin synchroniser
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;

    // Registers
    wdt_pkg::watchdog_control_t control_ff;
    wdt_pkg::watchdog_control_t nxt_control;
    wdt_pkg::reset_cause_t      cause_ff;
    wdt_pkg::reset_cause_t      nxt_cause;
    logic [CE_CW-1:0]           ce_cnt_ff;
    logic [CE_CW-1:0]           nxt_ce_cnt;
    logic [7:0]                 nxt_rdata;

    // Decoded state
    wdt_pkg::watchdog_control_t wr_value;
    wdt_pkg::wdt_mode_t         mode;
    logic                       fuse_programmed;
    logic                       brownout_active;
    logic                       extpin_active;
    logic                       wr_status;
    logic                       wr_control;
    logic                       eff_reset_enable;
    logic                       eff_irq_enable;
    logic                       running;
    logic                       osc_tick;
    logic                       timeout;
    logic                       irq_set_evt;
    logic                       wdog_reset_evt;
    logic                       any_system_reset;
    logic                       open_request;
    logic [3:0]                 period_code;

    // Mode from the enable bits and the fuse
    function automatic wdt_pkg::wdt_mode_t decode_mode(
        input logic fuse_prog,
        input logic rst_en,
        input logic irq_en
    );
        if (fuse_prog) begin
            return wdt_pkg::MODE_RESET;
        end
        case ({rst_en, irq_en})
            2'b00:   return wdt_pkg::MODE_STOPPED;
            2'b01:   return wdt_pkg::MODE_IRQ;
            2'b10:   return wdt_pkg::MODE_RESET;
            default: return wdt_pkg::MODE_IRQ_RESET;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] offset);
        return a == offset;
    endfunction

    // Reset sources and the fuse are asynchronous to this clock
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_meta_ff <= 3'h4;
            pin_sync_ff <= 3'h4;
        end else begin
            pin_meta_ff <= {always_on_fuse_b_in, extpin_rst_in, brownout_rst_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign fuse_programmed = ~pin_sync_ff[wdt_pkg::SYNC_FUSE];
    assign brownout_active = pin_sync_ff[wdt_pkg::SYNC_BROWNOUT];
    assign extpin_active   = pin_sync_ff[wdt_pkg::SYNC_EXTPIN];

    // Exact decode; other addresses ignore writes and read as zero
    assign wr_status  = wr_in && hit(addr_in, wdt_pkg::OFF_RESET_CAUSE_STATUS);
    assign wr_control = wr_in && hit(addr_in, wdt_pkg::OFF_WATCHDOG_CONTROL);
    assign wr_value   = wdt_pkg::watchdog_control_t'(wdata_in);

    // Fuse locks reset-enable to one and interrupt-enable to zero
    assign eff_reset_enable = fuse_programmed | control_ff.sys_reset_enable;
    assign eff_irq_enable   = ~fuse_programmed & control_ff.timeout_irq_enable;

    assign mode = decode_mode(fuse_programmed,
                              eff_reset_enable,
                              eff_irq_enable);

    // Stopped mode holds the count at zero
    assign running     = (mode != wdt_pkg::MODE_STOPPED);
    // Period bits sit on both sides of the change-enable bit
    assign period_code = {control_ff.period_select_hi, control_ff.period_select_lo};

    osc_tick_divider #(
        .DIV (OSC_DIV)
    ) u_tick (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .tick_out (osc_tick)
    );

    // A system reset restarts the count, as the whole chip restarts
    timeout_counter #(
        .CNT_W      (wdt_pkg::TIMEOUT_CNT_W),
        .BASE_TICKS (BASE_TICKS)
    ) u_counter (
        .clock_in         (clock_in),
        .rst_b_in         (rst_b_in),
        .tick_in          (osc_tick),
        .run_in           (running),
        .restart_in       (wdog_restart_in | any_system_reset),
        .period_select_in (period_code),
        .timeout_out      (timeout)
    );

    // Action on time-out per mode
    always_comb begin
        irq_set_evt    = 1'b0;
        wdog_reset_evt = 1'b0;
        case (mode)
            wdt_pkg::MODE_IRQ: begin
                irq_set_evt = timeout;
            end
            wdt_pkg::MODE_RESET: begin
                wdog_reset_evt = timeout;
            end
            wdt_pkg::MODE_IRQ_RESET: begin
                // Unserviced flag means the handler never ran
                wdog_reset_evt = timeout & control_ff.timeout_irq_flag;
                irq_set_evt    = timeout & ~control_ff.timeout_irq_flag;
            end
            default: begin
                irq_set_evt    = 1'b0;
                wdog_reset_evt = 1'b0;
            end
        endcase
    end

    // Brown-out and pin reset act for as long as their level is high
    assign any_system_reset = wdog_reset_evt | brownout_active | extpin_active;

    // Opening the change window needs both bits in one write
    assign open_request = wr_value.change_enable & wr_value.sys_reset_enable;

    // Control register next value
    always_comb begin
        nxt_control = control_ff;
        nxt_ce_cnt  = ce_cnt_ff;
        // Window closes on the fourth edge after the opening write
        if (control_ff.change_enable) begin
            if (ce_cnt_ff == '0) begin
                nxt_control.change_enable = 1'b0;
            end else begin
                nxt_ce_cnt = ce_cnt_ff - 1'b1;
            end
        end
        if (wr_control) begin
            if (wr_value.timeout_irq_flag) begin
                nxt_control.timeout_irq_flag = 1'b0;
            end
            nxt_control.timeout_irq_enable = wr_value.timeout_irq_enable;
            if (control_ff.change_enable) begin
                nxt_control.sys_reset_enable = wr_value.sys_reset_enable;
                nxt_control.period_select_hi = wr_value.period_select_hi;
                nxt_control.period_select_lo = wr_value.period_select_lo;
            end else begin
                // Setting reset-enable is always allowed, clearing is not
                nxt_control.sys_reset_enable = control_ff.sys_reset_enable
                                             | wr_value.sys_reset_enable;
            end
            if (open_request) begin
                nxt_control.change_enable = 1'b1;
                nxt_ce_cnt                = CE_LOAD;
            end else if (!wr_value.change_enable) begin
                nxt_control.change_enable = 1'b0;
            end
        end
        if (irq_vector_ack_in) begin
            nxt_control.timeout_irq_flag = 1'b0;
            if (control_ff.sys_reset_enable) begin
                nxt_control.timeout_irq_enable = 1'b0;
            end
        end
        // Hardware set wins over a software or vector clear
        if (irq_set_evt) begin
            nxt_control.timeout_irq_flag = 1'b1;
        end
        // System reset clears the register but keeps reset-enable
        if (any_system_reset) begin
            nxt_control                  = wdt_pkg::CONTROL_RST;
            nxt_control.sys_reset_enable = control_ff.sys_reset_enable;
            nxt_ce_cnt                   = '0;
        end
        if (cause_ff.wdog_reset_cause_flag || wdog_reset_evt) begin
            nxt_control.sys_reset_enable = 1'b1;
        end
        // Fuse lock last, so no write or event can undo it
        if (fuse_programmed) begin
            nxt_control.sys_reset_enable   = 1'b1;
            nxt_control.timeout_irq_enable = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            control_ff <= wdt_pkg::CONTROL_RST;
            ce_cnt_ff  <= '0;
        end else begin
            control_ff <= nxt_control;
            ce_cnt_ff  <= nxt_ce_cnt;
        end
    end

    // Reset-cause flags: written zero clears, set wins over clear
    always_comb begin
        nxt_cause = cause_ff;
        if (wr_status) begin
            if (!wdata_in[3]) begin
                nxt_cause.wdog_reset_cause_flag = 1'b0;
            end
            if (!wdata_in[2]) begin
                nxt_cause.brownout_cause_flag = 1'b0;
            end
            if (!wdata_in[1]) begin
                nxt_cause.extpin_cause_flag = 1'b0;
            end
            if (!wdata_in[0]) begin
                nxt_cause.poweron_cause_flag = 1'b0;
            end
        end
        if (wdog_reset_evt) begin
            nxt_cause.wdog_reset_cause_flag = 1'b1;
        end
        if (brownout_active) begin
            nxt_cause.brownout_cause_flag = 1'b1;
        end
        if (extpin_active) begin
            nxt_cause.extpin_cause_flag = 1'b1;
        end
    end

    // Only power-on reset reaches these flops; others are logged events
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cause_ff <= wdt_pkg::CAUSE_RST;
        end else begin
            cause_ff <= nxt_cause;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_in) begin
            if (hit(addr_in, wdt_pkg::OFF_RESET_CAUSE_STATUS)) begin
                nxt_rdata = {wdt_pkg::CAUSE_UNUSED, cause_ff};
            end else if (hit(addr_in, wdt_pkg::OFF_WATCHDOG_CONTROL)) begin
                nxt_rdata = control_ff;
            end
        end
    end

    // Zero outside the answer cycle; a stale byte is never left standing
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= nxt_rdata;
        end
    end

    // Interrupt request and reset pulse
    // Registered, so the request trails the flag by one cycle
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            timeout_irq_req_out <= 1'b0;
        end else begin
            timeout_irq_req_out <= control_ff.timeout_irq_flag
                                 & eff_irq_enable
                                 & global_irq_enable_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sys_reset_pulse_out <= 1'b0;
        end else begin
            sys_reset_pulse_out <= wdog_reset_evt;
        end
    end

    // Status only; the mode itself is decoded from the flops above
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_out <= 2'h0;
        end else begin
            mode_out <= mode;
        end
    end

endmodule // watchdog_timer_reset_flags

// ### design/wdt_pkg.sv
package wdt_pkg;

    // Register offsets in the processor register space
    localparam logic [7:0] OFF_RESET_CAUSE_STATUS = 8'h35;
    localparam logic [7:0] OFF_WATCHDOG_CONTROL   = 8'h60;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       timeout_irq_flag;
        logic       timeout_irq_enable;
        logic       period_select_hi;
        logic       change_enable;
        logic       sys_reset_enable;
        logic [2:0] period_select_lo;
    } watchdog_control_t;

    // Reset-cause flags, bits 3..0; bits 7..4 read as zero
    typedef struct packed {
        logic wdog_reset_cause_flag;
        logic brownout_cause_flag;
        logic extpin_cause_flag;
        logic poweron_cause_flag;
    } reset_cause_t;

    typedef enum logic [1:0] {
        MODE_STOPPED,
        MODE_IRQ,
        MODE_RESET,
        MODE_IRQ_RESET
    } wdt_mode_t;

    localparam watchdog_control_t CONTROL_RST = 8'h00;
    localparam reset_cause_t      CAUSE_RST   = 4'h1;
    localparam logic [3:0]        CAUSE_UNUSED = 4'h0;

    // Timing
    localparam int CLK_FREQ_HZ      = 10000000;
    localparam int OSC_FREQ_HZ      = 128000;
    localparam int OSC_DIV          = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int CHANGE_WINDOW_CYC = 4;
    localparam int BASE_OSC_CYCLES  = 2048;
    localparam int MAX_PERIOD_CODE  = 9;
    localparam int TIMEOUT_CNT_W    = 21;

    // Pin synchroniser bit positions
    localparam int SYNC_BROWNOUT = 0;
    localparam int SYNC_EXTPIN   = 1;
    localparam int SYNC_FUSE     = 2;

endpackage

// ### design/osc_tick_divider.sv
`timescale 1ns/10ps
module osc_tick_divider #(
    parameter int DIV = wdt_pkg::OSC_DIV
) (
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    output logic      tick_out
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] div_cnt_ff;

    // Free running, like the dedicated oscillator it stands in for
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_cnt_ff <= '0;
            tick_out   <= 1'b0;
        end else begin
            tick_out   <= (div_cnt_ff == LAST);
            div_cnt_ff <= (div_cnt_ff == LAST) ? '0 : div_cnt_ff + 1'b1;
        end
    end

endmodule // osc_tick_divider

// ### design/timeout_counter.sv
`timescale 1ns/10ps
module timeout_counter #(
    parameter int CNT_W      = wdt_pkg::TIMEOUT_CNT_W,
    parameter int BASE_TICKS = wdt_pkg::BASE_OSC_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       tick_in,
    input  wire logic       run_in,
    input  wire logic       restart_in,
    input  wire logic [3:0] period_select_in,
    output logic            timeout_out
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] limit;

    // Reserved codes behave as the longest period
    function automatic logic [CNT_W-1:0] period_limit(input logic [3:0] code);
        logic [3:0] c;
        c = (code > 4'(wdt_pkg::MAX_PERIOD_CODE)) ? 4'(wdt_pkg::MAX_PERIOD_CODE) : code;
        return (CNT_W'(BASE_TICKS) << c) - 1'b1;
    endfunction

    assign limit = period_limit(period_select_in);

    // >= so that a shorter period taking effect times out at once
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_ff      <= '0;
            timeout_out <= 1'b0;
        end else if (restart_in || !run_in) begin
            cnt_ff      <= '0;
            timeout_out <= 1'b0;
        end else if (tick_in) begin
            timeout_out <= (cnt_ff >= limit);
            cnt_ff      <= (cnt_ff >= limit) ? '0 : cnt_ff + 1'b1;
        end else begin
            timeout_out <= 1'b0;
        end
    end

endmodule // timeout_counter

// ### verif/watchdog_timer_reset_flags_properties.sv
`timescale 1ns/10ps
module watchdog_timer_reset_flags_checker #(
    parameter int OSC_DIV    = wdt_pkg::OSC_DIV,
    parameter int BASE_TICKS = wdt_pkg::BASE_OSC_CYCLES
) (
    input wire logic       clock_in,
    input wire logic       rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       brownout_rst_in,
    input wire logic       extpin_rst_in,
    input wire logic       always_on_fuse_b_in,
    input wire logic       global_irq_enable_in,
    input wire logic       irq_vector_ack_in,
    input wire logic       wdog_restart_in,
    input wire logic       timeout_irq_req_out,
    input wire logic       sys_reset_pulse_out,
    input wire logic [1:0] mode_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    AST_CAUSE_UPPER_ZERO: assert property (
        $past(rd_in) && $past(addr_in) == 8'h35 |-> rdata_out[7:4] == 4'h0)
        else $error("cause upper bits not zero");
    AST_IRQ_NEEDS_GLOBAL: assert property (
        timeout_irq_req_out |-> $past(global_irq_enable_in))
        else $error("request without global enable");
    AST_RESET_PULSE_ONE: assert property (
        sys_reset_pulse_out |=> !sys_reset_pulse_out)
        else $error("reset pulse too long");
    AST_PULSE_MODE: assert property (
        sys_reset_pulse_out |-> $past(mode_out) inside {2'd2, 2'd3})
        else $error("reset pulse outside reset modes");
    AST_FUSE_FORCES_RESET: assert property (
        (!always_on_fuse_b_in) [*4] |-> mode_out == 2'd2)
        else $error("fuse did not force reset mode");
    AST_CHANGE_EXPIRES: assert property (
        wr_in && addr_in == 8'h60 && wdata_in[4] && wdata_in[3] ##1 (!wr_in) [*4]
        ##1 (rd_in && addr_in == 8'h60) |=> !rdata_out[4])
        else $error("change enable still set");
    AST_VECTOR_CLEARS_REQ: assert property (
        irq_vector_ack_in |-> ##2 !timeout_irq_req_out)
        else $error("request kept after vector");
    AST_STAYS_ENABLED: assert property (
        sys_reset_pulse_out |-> ##2 mode_out == 2'd2)
        else $error("watchdog left reset mode");
    AST_RESTART_HOLDS_OFF: assert property (
        wdog_restart_in |-> ##2 (!sys_reset_pulse_out) [*4])
        else $error("time-out right after restart");
endmodule // watchdog_timer_reset_flags_checker

bind watchdog_timer_reset_flags watchdog_timer_reset_flags_checker #(
    .OSC_DIV(OSC_DIV), .BASE_TICKS(BASE_TICKS)) i_checker (
    .clock_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .brownout_rst_in, .extpin_rst_in, .always_on_fuse_b_in, .global_irq_enable_in,
    .irq_vector_ack_in, .wdog_restart_in, .timeout_irq_req_out, .sys_reset_pulse_out,
    .mode_out);

// ### verif/watchdog_timer_reset_flags_tb_top.sv
`timescale 1ns/10ps
module watchdog_timer_reset_flags_tb_top;
    localparam int DIV  = 2;
    localparam int BASE = 4;
    logic       clock_in;
    logic       rst_b_in;
    logic [7:0] addr_in;
    logic [7:0] wdata_in;
    logic       wr_in;
    logic       rd_in;
    logic [7:0] rdata_out;
    logic       brownout_rst_in;
    logic       extpin_rst_in;
    logic       always_on_fuse_b_in;
    logic       global_irq_enable_in;
    logic       irq_vector_ack_in;
    logic       wdog_restart_in;
    logic       timeout_irq_req_out;
    logic       sys_reset_pulse_out;
    logic [1:0] mode_out;
    int         miscompares = 0;
    int         tests_run = 0;
    int         pulses = 0;
    int         n0;
    int         per;
    logic       found;
    logic [7:0] a;
    time        t0;
    int         codes[5] = '{15, 0, 1, 2, 9};

    watchdog_timer_reset_flags #(.OSC_DIV(DIV), .BASE_TICKS(BASE)) i_dut (
        .clock_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .brownout_rst_in, .extpin_rst_in, .always_on_fuse_b_in, .global_irq_enable_in,
        .irq_vector_ack_in, .wdog_restart_in, .timeout_irq_req_out,
        .sys_reset_pulse_out, .mode_out);

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        if (sys_reset_pulse_out === 1'b1) pulses <= pulses + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock_in);
        addr_in  <= ad;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    // Read data stand one cycle only, so sample them mid-cycle
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clock_in);
        addr_in <= ad;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        check(rdata_out, exp);
        @(negedge clock_in);
        check(rdata_out, 8'h00);
    endtask

    task automatic pulse(input int sel);
        @(posedge clock_in);
        if (sel == 0) brownout_rst_in <= 1'b1;
        if (sel == 1) extpin_rst_in <= 1'b1;
        if (sel == 2) irq_vector_ack_in <= 1'b1;
        if (sel == 3) wdog_restart_in <= 1'b1;
        repeat (sel < 2 ? 4 : 1) @(posedge clock_in);
        {brownout_rst_in, extpin_rst_in, irq_vector_ack_in, wdog_restart_in} <= 4'h0;
        repeat (sel < 2 ? 4 : 0) @(posedge clock_in);
        repeat (sel == 2 ? 2 : 0) @(negedge clock_in);
    endtask

    // Bounded wait; a missed event shows up as found low
    task automatic wait_sig(input bit rst_sel, input int limit);
        int n;
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
            found = rst_sel ? sys_reset_pulse_out : timeout_irq_req_out;
        end while (found !== 1'b1 && n < limit);
    endtask

    function automatic logic [7:0] enc(input int c);
        return {2'h0, c[3], 2'h0, c[2:0]};
    endfunction

    task automatic end_of_test();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #8_000_000;
        miscompares++;
        end_of_test();
    end

    initial begin
        n0 = $urandom(32'h3D07);
        {rst_b_in, addr_in, wdata_in, wr_in, rd_in} = 19'h0;
        {brownout_rst_in, extpin_rst_in, irq_vector_ack_in, wdog_restart_in} = 4'h0;
        always_on_fuse_b_in  = 1'b1;
        global_irq_enable_in = 1'b1;
        repeat (4) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rd_chk(8'h35, 8'h01);
        repeat (8) begin
            a = 8'($urandom);
            if (a == 8'h35 || a == 8'h60) a = a ^ 8'h01;
            wr(a, 8'($urandom));
        end
        rd_chk(8'h35, 8'h01);
        rd_chk(8'h60, 8'h00);
        pulse(0);
        rd_chk(8'h35, 8'h05);
        pulse(1);
        rd_chk(8'h35, 8'h07);
        wr(8'h35, {4'($urandom), 4'h6});
        rd_chk(8'h35, 8'h06);
        wr(8'h35, {4'($urandom), 4'h0});
        rd_chk(8'h35, 8'h00);
        foreach (codes[i]) begin
            per = (BASE << (codes[i] > 9 ? 9 : codes[i])) * DIV;
            wr(8'h60, 8'h58);
            wr(8'h60, 8'h40 | enc(codes[i]));
            wait_sig(1'b0, per + 50);
            t0 = $time;
            pulse(2);
            wait_sig(1'b0, per + 50);
            check(found, 1'b1);
            check(mode_out, 2'd1);
            check(int'(($time - t0) / 100) inside {[per:per + DIV]}, 1'b1);
            pulse(2);
        end
        wait_sig(1'b0, 5000);
        wr(8'h60, 8'hE1);
        rd_chk(8'h60, 8'h61);
        @(posedge clock_in);
        global_irq_enable_in <= 1'b0;
        repeat (4200) @(negedge clock_in);
        check(timeout_irq_req_out, 1'b0);
        rd_chk(8'h60, 8'hE1);
        @(posedge clock_in);
        global_irq_enable_in <= 1'b1;
        repeat (3) @(negedge clock_in);
        check(timeout_irq_req_out, 1'b1);
        wr(8'h60, 8'h62);
        rd_chk(8'h60, 8'hE1);
        wr(8'h60, 8'hE9);
        rd_chk(8'h60, 8'h69);
        check(mode_out, 2'd3);
        wr(8'h60, 8'h61);
        rd_chk(8'h60, 8'h69);
        wr(8'h60, 8'h79);
        repeat (3) @(posedge clock_in);
        rd_chk(8'h60, 8'h69);
        wr(8'h60, 8'h61);
        rd_chk(8'h60, 8'h69);
        // Restart before shortening the period, else it expires at once
        wr(8'h60, 8'h79);
        pulse(3);
        wr(8'h60, 8'h48);
        repeat (10) pulse(3);
        rd_chk(8'h60, 8'h48);
        n0 = pulses;
        wait_sig(1'b0, 100);
        check(pulses, n0);
        pulse(2);
        rd_chk(8'h60, 8'h08);
        wait_sig(1'b1, 100);
        check(found, 1'b1);
        rd_chk(8'h35, 8'h08);
        rd_chk(8'h60, 8'h08);
        wait_sig(1'b1, 100);
        // Power-on reset in mid-run clears the watchdog cause flag
        @(posedge clock_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rd_chk(8'h35, 8'h01);
        wr(8'h60, 8'h48);
        wait_sig(1'b0, 100);
        wait_sig(1'b1, 100);
        check(found, 1'b1);
        wr(8'h60, 8'h39);
        wr(8'h60, 8'h21);
        rd_chk(8'h60, 8'h29);
        wr(8'h35, 8'h00);
        rd_chk(8'h35, 8'h00);
        wr(8'h60, 8'h39);
        wr(8'h60, 8'h00);
        rd_chk(8'h60, 8'h00);
        n0 = pulses;
        repeat (100) @(negedge clock_in);
        check(pulses, n0);
        @(posedge clock_in);
        always_on_fuse_b_in <= 1'b0;
        repeat (5) @(negedge clock_in);
        check(mode_out, 2'd2);
        rd_chk(8'h60, 8'h08);
        wait_sig(1'b1, 100);
        check(found, 1'b1);
        end_of_test();
    end
endmodule // watchdog_timer_reset_flags_tb_top
